// File: logic/rtcsl_pkg.sv
// Notes on behaviour
// - sda falling while scl high is a start; it begins an access.
// - sda rising while scl high is a stop; the device returns to standby.
// - after a start, transfers go byte by byte, each with an acknowledge bit.
// - data changes only while scl low; a change during scl high aborts access.
// - master releases sda after eighth fall; device drives low during ninth clock.
// - the device withholds acknowledge when the access sequence is incorrect.
// - after start, device takes code and command; read/write bit one means read.
// - in read mode each byte is shifted out most significant bit first.
// - read/write bit zero after code and command means write-data mode.
// - in write mode the device acknowledges low after each data byte up to the group length.
// - status command select bit: zero first status, one second status register.
// - interrupt command select bit: zero first, one second interrupt register.
// - alarm enabled and frequency off: interrupt registers are three bytes; otherwise one byte.
// - while the device drives sda low it ignores a stop from the master.
// - an accepted stop resets interface state; a pending write may still complete.
package rtcsl_pkg;

   // apb map
   localparam logic [7:0] RTCSL_OFS_BANK  = 8'h00;
   localparam logic [7:0] RTCSL_OFS_CTRL  = 8'h80;
   localparam logic [7:0] RTCSL_OFS_STAT  = 8'h84;
   localparam int         RTCSL_CTRL_EN   = 0;

   // byte bank layout
   localparam int         RTCSL_BANK_N    = 17;
   localparam logic [4:0] RTCSL_B_STS1    = 5'h00;
   localparam logic [4:0] RTCSL_B_STS2    = 5'h01;
   localparam logic [4:0] RTCSL_B_RTD1    = 5'h02;
   localparam logic [4:0] RTCSL_B_RTD2    = 5'h06;
   localparam logic [4:0] RTCSL_B_FIRST_INTERRUPT_REGISTER    = 5'h09;
   localparam logic [4:0] RTCSL_B_SECOND_INTERRUPT_REGISTER    = 5'h0c;
   localparam logic [4:0] RTCSL_B_CORR    = 5'h0f;
   localparam logic [4:0] RTCSL_B_FREE    = 5'h10;
   localparam logic [2:0] RTCSL_LEN_RTD1  = 3'h7;
   localparam logic [2:0] RTCSL_LEN_RTD2  = 3'h3;
   localparam logic [2:0] RTCSL_LEN_ALARM = 3'h3;
   localparam logic [2:0] RTCSL_LEN_ONE   = 3'h1;
   localparam int         RTCSL_STS2_ALM  = 1;
   localparam int         RTCSL_STS2_FRQ  = 2;

   // command groups, the low command bit is the select bit
   localparam logic [1:0] RTCSL_GRP_STS   = 2'h0;
   localparam logic [1:0] RTCSL_GRP_RTD   = 2'h1;
   localparam logic [1:0] RTCSL_GRP_INT   = 2'h2;
   localparam logic [1:0] RTCSL_GRP_MISC  = 2'h3;

   localparam logic [3:0] RTCSL_BYTE_BITS = 4'h8;
   localparam int         RTCSL_SYNC_N    = 3;

   typedef struct packed {
      logic [3:0] dev_code;
      logic [1:0] group;
      logic       sel;
      logic       rd;
   } rtcsl_head_s;

   typedef struct packed {
      logic [11:0] zero;
      logic        last_rd;
      logic [2:0]  last_cmd;
      logic [7:0]  wr_count;
      logic [5:0]  zero2;
      logic        driving;
      logic        busy;
   } rtcsl_stat_s;

endpackage

// File: logic/rtcsl_slave.sv
`timescale 1ns/10ps
module rtcsl_slave #(
   parameter logic [3:0] DEV_CODE = 4'ha  // arbitrary value
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        scl_i,
   input  wire logic        sda_i,
   output logic             sda_o,
   output logic             sda_oe_n
);
   import rtcsl_pkg::*;

   if (RTCSL_SYNC_N != 3) begin : g_chk
      $error("synchroniser depth must be three");
   end

   typedef enum logic [2:0] {
      ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_WR, ST_WR_ACK, ST_RD, ST_RD_ACK, ST_WAIT
   } rtcsl_state_e;

   rtcsl_state_e  state_r;
   logic [7:0]    bank_r [RTCSL_BANK_N];
   logic [RTCSL_SYNC_N-1:0] sync_r [2];
   logic [1:0]    filt_r;
   logic [1:0]    prev_r;
   logic          scl_f, sda_f, scl_p, sda_p;
   logic          scl_rise, scl_fall, start_det, stop_det;
   logic [3:0]    cnt_r;
   logic [7:0]    rx_r;
   logic [7:0]    tx_r;
   logic          drive_r;
   logic          ack_r;
   logic [2:0]    idx_r;
   rtcsl_head_s   head_r;
   rtcsl_head_s   head_new;
   logic [4:0]    base;
   logic [2:0]    len;
   logic [2:0]    rd_idx;
   logic [4:0]    rd_addr;
   logic          wr_fire;
   logic          en_r;
   logic [7:0]    wr_count_r;
   logic          apb_wr;
   logic          apb_bank;
   logic [4:0]    apb_idx;
   logic [31:0]   prdata_r;
   logic          pslverr_r;
   rtcsl_stat_s   stat;

   // pin synchronisers; a level counts once stages two and three agree
   for (genvar p = 0; p < 2; p++) begin : g_sync
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            sync_r[p] <= '1;
            filt_r[p] <= 1'b1;
            prev_r[p] <= 1'b1;
         end else begin
            sync_r[p] <= {sync_r[p][RTCSL_SYNC_N-2:0], (p == 0) ? scl_i : sda_i};
            if (sync_r[p][1] == sync_r[p][2]) begin
               filt_r[p] <= sync_r[p][2];
            end
            prev_r[p] <= filt_r[p];
         end
      end
   end

   assign scl_f    = filt_r[0];
   assign sda_f    = filt_r[1];
   assign scl_p    = prev_r[0];
   assign sda_p    = prev_r[1];
   assign scl_rise = scl_f & ~scl_p;
   assign scl_fall = ~scl_f & scl_p;
   // a data change under steady high clock is framing, never data
   assign start_det = scl_f & scl_p & sda_p & ~sda_f;
   assign stop_det  = scl_f & scl_p & ~sda_p & sda_f;

   assign head_new = rtcsl_head_s'(rx_r);

   // register group selected by the latched command
   always_comb begin
      base = RTCSL_B_STS1;
      len  = RTCSL_LEN_ONE;
      case (head_r.group)
         RTCSL_GRP_STS: begin
            base = head_r.sel ? RTCSL_B_STS2 : RTCSL_B_STS1;
         end
         RTCSL_GRP_RTD: begin
            base = head_r.sel ? RTCSL_B_RTD2 : RTCSL_B_RTD1;
            len  = head_r.sel ? RTCSL_LEN_RTD2 : RTCSL_LEN_RTD1;
         end
         RTCSL_GRP_INT: begin
            base = head_r.sel ? RTCSL_B_SECOND_INTERRUPT_REGISTER : RTCSL_B_FIRST_INTERRUPT_REGISTER;
            // frequency mode keeps one byte even if alarm is also set
            if (bank_r[RTCSL_B_STS2][RTCSL_STS2_ALM] &&
                !bank_r[RTCSL_B_STS2][RTCSL_STS2_FRQ]) begin
               len = RTCSL_LEN_ALARM;
            end else begin
               len = RTCSL_LEN_ONE;
            end
         end
         default: begin
            base = head_r.sel ? RTCSL_B_FREE : RTCSL_B_CORR;
         end
      endcase
   end

   // reads past the group's end wrap to its first byte
   assign rd_idx  = (idx_r < len) ? idx_r : 3'h0;
   assign rd_addr = 5'(base + 5'(rd_idx));
   // bytes beyond the group length are refused with no acknowledge
   assign wr_fire = (state_r == ST_WR) && scl_fall && (cnt_r == RTCSL_BYTE_BITS)
                    && (idx_r < len);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= ST_IDLE;
         cnt_r   <= 4'h0;
         rx_r    <= 8'h00;
         tx_r    <= 8'h00;
         drive_r <= 1'b0;
         ack_r   <= 1'b0;
         idx_r   <= 3'h0;
         head_r  <= '0;
      end else if (!en_r) begin
         state_r <= ST_IDLE;
         drive_r <= 1'b0;
      end else if (start_det && !drive_r) begin
         state_r <= ST_ADDR;
         cnt_r   <= 4'h0;
      end else if (stop_det && !drive_r) begin
         state_r <= ST_IDLE;
      end else begin
         // while driving low a stop also reaches here and is ignored
         case (state_r)
            ST_ADDR, ST_WR: begin
               if (scl_rise && cnt_r != RTCSL_BYTE_BITS) begin
                  rx_r  <= {rx_r[6:0], sda_f};
                  cnt_r <= cnt_r + 4'h1;
               end else if (scl_fall && cnt_r == RTCSL_BYTE_BITS) begin
                  if (state_r == ST_ADDR) begin
                     if (head_new.dev_code == DEV_CODE) begin
                        head_r  <= head_new;
                        drive_r <= 1'b1;
                        idx_r   <= 3'h0;
                        state_r <= ST_ADDR_ACK;
                     end else begin
                        state_r <= ST_WAIT;
                     end
                  end else if (wr_fire) begin
                     drive_r <= 1'b1;
                     idx_r   <= idx_r + 3'h1;
                     state_r <= ST_WR_ACK;
                  end else begin
                     state_r <= ST_WAIT;
                  end
               end
            end
            ST_ADDR_ACK, ST_WR_ACK: begin
               if (scl_fall) begin
                  cnt_r <= 4'h0;
                  if (head_r.rd) begin
                     tx_r    <= bank_r[rd_addr];
                     drive_r <= ~bank_r[rd_addr][7];
                     idx_r   <= rd_idx + 3'h1;
                     state_r <= ST_RD;
                  end else begin
                     drive_r <= 1'b0;
                     state_r <= ST_WR;
                  end
               end
            end
            ST_RD: begin
               if (scl_fall) begin
                  if (cnt_r == RTCSL_BYTE_BITS - 4'h1) begin
                     drive_r <= 1'b0;
                     state_r <= ST_RD_ACK;
                  end else begin
                     tx_r    <= {tx_r[6:0], 1'b0};
                     drive_r <= ~tx_r[6];
                     cnt_r   <= cnt_r + 4'h1;
                  end
               end
            end
            ST_RD_ACK: begin
               if (scl_rise) begin
                  ack_r <= ~sda_f;
               end else if (scl_fall) begin
                  cnt_r <= 4'h0;
                  if (ack_r) begin
                     tx_r    <= bank_r[rd_addr];
                     drive_r <= ~bank_r[rd_addr][7];
                     idx_r   <= rd_idx + 3'h1;
                     state_r <= ST_RD;
                  end else begin
                     state_r <= ST_WAIT;
                  end
               end
            end
            default: begin
               drive_r <= 1'b0;
            end
         endcase
      end
   end

   // apb decode
   assign apb_idx  = paddr[6:2];
   assign apb_bank = (paddr[7] == 1'b0) && (paddr[1:0] == 2'h0) &&
                     (apb_idx < 5'(RTCSL_BANK_N));
   assign apb_wr   = psel && penable && pwrite;

   // a serial write wins over a same-cycle apb write to the bank
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < RTCSL_BANK_N; i++) begin
            bank_r[i] <= 8'h00;
         end
      end else if (wr_fire) begin
         bank_r[5'(base + 5'(idx_r))] <= rx_r;
      end else if (apb_wr && apb_bank) begin
         bank_r[apb_idx] <= pwdata[7:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         en_r <= 1'b0;
      end else if (apb_wr && paddr == RTCSL_OFS_CTRL) begin
         en_r <= pwdata[RTCSL_CTRL_EN];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wr_count_r <= 8'h00;
      end else if (wr_fire) begin
         wr_count_r <= wr_count_r + 8'h01;
      end
   end

   always_comb begin
      stat          = '0;
      stat.busy     = (state_r != ST_IDLE);
      stat.driving  = drive_r;
      stat.wr_count = wr_count_r;
      stat.last_cmd = {head_r.group, head_r.sel};
      stat.last_rd  = head_r.rd;
   end

   // read data is captured in the setup cycle so it leaves a flip-flop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r  <= 32'h0000_0000;
         pslverr_r <= 1'b0;
      end else if (psel && !penable) begin
         prdata_r  <= 32'h0000_0000;
         pslverr_r <= 1'b0;
         if (apb_bank) begin
            prdata_r <= {24'h00_0000, bank_r[apb_idx]};
         end else if (paddr == RTCSL_OFS_CTRL) begin
            prdata_r <= {31'h0000_0000, en_r};
         end else if (paddr == RTCSL_OFS_STAT) begin
            prdata_r <= stat;
         end else begin
            pslverr_r <= 1'b1;
         end
      end
   end

   assign pready   = psel && penable;
   assign prdata   = prdata_r;
   assign pslverr  = pslverr_r && psel && penable;
   assign sda_o    = 1'b0;
   assign sda_oe_n = ~drive_r;

endmodule

// File: tb/rtcsl_i2c_master.sv
`timescale 1ns/10ps
module rtcsl_i2c_master (
   output logic      scl,
   output logic      sda_m,
   input  wire logic sda_w
);
   localparam int Q = 16;  // quarter of the 64 ns link period
   // idle, released bus from time zero; no traffic before software starts one
   initial begin
      scl = 1'b1;
      sda_m = 1'b1;
   end
   task automatic start_c;
      #Q sda_m = 1'b1;
      #Q scl = 1'b1;
      #Q sda_m = 1'b0;
      #Q scl = 1'b0;
   endtask
   task automatic stop_c;
      #Q sda_m = 1'b0;
      #Q scl = 1'b1;
      #Q sda_m = 1'b1;
      #Q;
   endtask
   // data moves only in the low half, sampled mid high
   task automatic bit_x(input logic b, output logic s);
      #Q sda_m = b;
      #Q scl = 1'b1;
      #Q s = sda_w;
      #Q scl = 1'b0;
   endtask
   task automatic xfer(input logic [7:0] d, input logic a_in, output logic [7:0] q,
                       output logic a_out);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_x(d[i], s);
         q[i] = s;
      end
      bit_x(a_in, a_out);
   endtask
   // frees a device stuck mid read or mid acknowledge
   task automatic flush;
      logic s;
      start_c();
      repeat (63) bit_x(1'b1, s);
      stop_c();
   endtask
endmodule

// File: tb/rtcsl_slave_sva.sv
`timescale 1ns/10ps
module rtcsl_slave_sva (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        scl_i,
   input wire logic        sda_i,
   input wire logic        sda_o,
   input wire logic        sda_oe_n
);
   import rtcsl_pkg::*;
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   property p_ready;
      pready == (psel && penable);
   endproperty
   a_ready: assert property (p_ready) else $error("pready off the access phase");
   property p_unmapped;
      psel && penable && paddr > RTCSL_OFS_STAT |-> pslverr && prdata == 32'h0;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
   property p_mapped;
      psel && penable && paddr == RTCSL_OFS_CTRL |-> !pslverr;
   endproperty
   a_mapped: assert property (p_mapped) else $error("mapped access refused");
   property p_err_only;
      pslverr |-> pready;
   endproperty
   a_err_only: assert property (p_err_only) else $error("error outside access");
   property p_od;
      sda_o == 1'b0;
   endproperty
   a_od: assert property (p_od) else $error("sda output not open drain");
   property p_pull_low_clk;
      $fell(sda_oe_n) |-> !scl_i;
   endproperty
   a_pull_low_clk: assert property (p_pull_low_clk) else $error("sda pulled in scl high");
   property p_rel_low_clk;
      $rose(sda_oe_n) |-> !scl_i;
   endproperty
   a_rel_low_clk: assert property (p_rel_low_clk) else $error("sda freed in scl high");
   property p_ack_hold;
      $fell(sda_oe_n) |-> !sda_oe_n [*8];
   endproperty
   a_ack_hold: assert property (p_ack_hold) else $error("sda low pulse too short");
   property p_wire_low;
      !sda_oe_n |-> !sda_i;
   endproperty
   a_wire_low: assert property (p_wire_low) else $error("sda wire not low");
endmodule
bind rtcsl_slave rtcsl_slave_sva i_rtcsl_slave_sva (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_i(scl_i), .sda_i(sda_i),
   .sda_o(sda_o), .sda_oe_n(sda_oe_n));

// File: tb/tb_rtc_two_wire_slave_interface.sv
`timescale 1ns/10ps
module tb_rtc_two_wire_slave_interface;
   import rtcsl_pkg::*;
   localparam logic [3:0] DEV = 4'ha;  // arbitrary value
   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        scl;
   logic        sda_m;
   logic        sda_o;
   logic        sda_oe_n;
   wire         sda_w = sda_m & (sda_oe_n | sda_o);
   logic [31:0] q;
   logic        e;
   int          n_mismatch = 0;
   int          n_checks = 0;
   logic [7:0]  first_interrupt_register_v [3] = '{8'ha1, 8'hb2, 8'hc3};
   rtcsl_slave #(.DEV_CODE(DEV)) i_rtcsl_slave (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_i(scl), .sda_i(sda_w),
      .sda_o(sda_o), .sda_oe_n(sda_oe_n));
   rtcsl_i2c_master i_rtcsl_i2c_master (.scl(scl), .sda_m(sda_m), .sda_w(sda_w));
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   task close_out;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      n_checks++;
      if (got !== ex) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", nm, ex, got);
      end
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 16) begin
         @(posedge pclk);
         n++;
      end
      if (n == 16) n_mismatch++;
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   function automatic logic [7:0] hd(input logic [1:0] g, input logic s, input logic r);
      return {DEV, g, s, r};
   endfunction
   task s_wr(input logic [7:0] d, input logic ea);
      logic [7:0] r;
      logic       a;
      i_rtcsl_i2c_master.xfer(d, 1'b1, r, a);
      chk("ack", {31'h0, ea}, {31'h0, a});
   endtask
   task s_rd(input logic a_in, input logic [7:0] ex);
      logic [7:0] r;
      logic       a;
      i_rtcsl_i2c_master.xfer(8'hff, a_in, r, a);
      chk("read byte", {24'h0, ex}, {24'h0, r});
   endtask
   initial begin
      #300000;
      n_mismatch++;
      close_out();
   end
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, RTCSL_OFS_CTRL, 32'h0);
      chk("ctrl reset", 32'h0, q);
      apb(1'b1, RTCSL_OFS_CTRL, 32'h1);
      apb(1'b1, 8'h00, 32'h5a);
      apb(1'b1, 8'h04, 32'h02);
      for (int i = 0; i < 3; i++) apb(1'b1, 8'h24 + 8'(4 * i), {24'h0, first_interrupt_register_v[i]});
      apb(1'b0, 8'hfc, 32'h0);
      chk("unmapped err", 32'h1, {31'h0, e});
      chk("unmapped data", 32'h0, q);
      i_rtcsl_i2c_master.start_c();
      s_wr(hd(RTCSL_GRP_STS, 1'b0, 1'b1), 1'b0);
      s_rd(1'b1, 8'h5a);
      i_rtcsl_i2c_master.start_c();
      s_wr(hd(RTCSL_GRP_STS, 1'b1, 1'b1), 1'b0);
      s_rd(1'b1, 8'h02);
      i_rtcsl_i2c_master.start_c();
      s_wr(hd(RTCSL_GRP_INT, 1'b0, 1'b1), 1'b0);
      for (int i = 0; i < 3; i++) s_rd(i == 2, first_interrupt_register_v[i]);
      i_rtcsl_i2c_master.stop_c();
      i_rtcsl_i2c_master.start_c();
      s_wr(hd(RTCSL_GRP_MISC, 1'b1, 1'b0), 1'b0);
      s_wr(8'h3c, 1'b0);
      i_rtcsl_i2c_master.stop_c();
      apb(1'b0, 8'h40, 32'h0);
      chk("free byte", 32'h3c, q);
      apb(1'b0, RTCSL_OFS_STAT, 32'h0);
      chk("stat fields", 32'h00701, {20'h0, q[19:8]});
      chk("stat idle", 32'h0, {30'h0, q[1:0]});
      i_rtcsl_i2c_master.start_c();
      s_wr(hd(RTCSL_GRP_STS, 1'b0, 1'b0), 1'b0);
      s_wr(8'h11, 1'b0);
      s_wr(8'h22, 1'b1);
      i_rtcsl_i2c_master.stop_c();
      apb(1'b0, 8'h00, 32'h0);
      chk("status1 byte", 32'h11, q);
      i_rtcsl_i2c_master.start_c();
      s_wr({~DEV, 4'h1}, 1'b1);
      s_wr(8'h00, 1'b1);
      i_rtcsl_i2c_master.stop_c();
      // read of 8'h11 leaves the device pulling sda for bit 7
      i_rtcsl_i2c_master.start_c();
      s_wr(hd(RTCSL_GRP_STS, 1'b0, 1'b1), 1'b0);
      i_rtcsl_i2c_master.stop_c();
      chk("sda held", 32'h0, {31'h0, sda_w});
      i_rtcsl_i2c_master.flush();
      i_rtcsl_i2c_master.start_c();
      s_wr(hd(RTCSL_GRP_MISC, 1'b1, 1'b0), 1'b0);
      s_wr(8'h99, 1'b0);
      i_rtcsl_i2c_master.stop_c();
      apb(1'b0, 8'h40, 32'h0);
      chk("free after flush", 32'h99, q);
      // set the first real-time byte, then read it straight back
      i_rtcsl_i2c_master.start_c();
      s_wr(hd(RTCSL_GRP_RTD, 1'b0, 1'b0), 1'b0);
      s_wr(8'h47, 1'b0);
      i_rtcsl_i2c_master.stop_c();
      i_rtcsl_i2c_master.start_c();
      s_wr(hd(RTCSL_GRP_RTD, 1'b0, 1'b1), 1'b0);
      s_rd(1'b1, 8'h47);
      i_rtcsl_i2c_master.stop_c();
      apb(1'b0, 8'h08, 32'h0);
      chk("real-time byte", 32'h47, q);
      close_out();
   end
endmodule
